// ---- core/sub_test_trap_consts.vh ----
// constants for the subtract / test / trap execution datapath
`ifndef SUB_TEST_TRAP_CONSTS_VH
`define SUB_TEST_TRAP_CONSTS_VH
// ------------------------------------------------------------
// register map (byte addresses)
// ------------------------------------------------------------
`define REG_CTRL       8'h00
`define REG_OPA        8'h04
`define REG_OPB        8'h08
`define REG_OPC        8'h0C
`define REG_STATUS     8'h10
`define REG_RESULT     8'h14
`define REG_STORE      8'h18
`define REG_PC         8'h1C
`define REG_SP         8'h20
`define REG_VEC_BASE   8'h40
// ------------------------------------------------------------
// ctrl fields
// ------------------------------------------------------------
`define CTRL_OP_LSB    0
`define CTRL_MODE_LSB  4
`define CTRL_DST_LSB   8
`define CTRL_COND_LSB  16
`define CTRL_N_LSB     24
`define CTRL_GO_BIT    31
// ------------------------------------------------------------
// status word bit positions
// ------------------------------------------------------------
`define ST_C           0
`define ST_V           1
`define ST_Z           2
`define ST_N           3
`define ST_UF          4
`define ST_LV          5
`define ST_LUF         6
`define ST_OVM         7
`define ST_GIE         13
`define ST_RESET       32'h0000_0000
// ------------------------------------------------------------
// opcodes
// ------------------------------------------------------------
`define OP_SUB3        4'h0
`define OP_SUB_STORE   4'h1
`define OP_RSUB_BORROW 4'h2
`define OP_RSUB_FLOAT  4'h3
`define OP_RSUB_INT    4'h4
`define OP_EMU_IRQ     4'h5
`define OP_TRAP        4'h6
`define OP_TEST2       4'h7
`define OP_TEST3       4'h8
// ------------------------------------------------------------
// limits and cycle counts
// ------------------------------------------------------------
`define INT_REG_MAX    5'd27
`define FLT_REG_MAX    5'd7
`define EMU_CYCLES     3'd4
`define TRAP_CYCLES    3'd5
`define COND_COUNT     5'd20
`define VEC_COUNT      32
`endif

// ---- core/vec_mem.v ----
// small trap vector memory with registered read data
`timescale 1ns/1ps
module vec_mem #(
   parameter DEPTH = 32,
   parameter AW    = 5
) (
   // clock
   input  wire          hclk,
   input  wire          ce,
   // write port
   input  wire          we,
   input  wire [AW-1:0] waddr,
   input  wire [31:0]   wdata,
   // read port
   input  wire [AW-1:0] raddr,
   output reg  [31:0]   rdata
);
   reg [31:0] mem [0:DEPTH-1];

   // no reset on storage: contents are software owned
   always @(posedge hclk) begin
      if (ce) begin
         if (we) begin
            mem[waddr] <= wdata;
         end
         rdata <= mem[raddr];
      end
   end
endmodule

// ---- core/sub_test_trap_exec.v ----
// execution datapath for subtract, test and trap instructions
//
// Notes on behaviour
// RULE1: three-operand mode selects register or indirect sources
// RULE2: indirect displacement is zero, one, or index
// RULE3: two-operand mode: register, direct, indirect, immediate
// RULE4: float forms use registers zero to seven
// RULE5: negative and zero flags follow result
// RULE6: overflow tracks signed overflow, underflow cleared
// RULE7: latched overflow sets sticky, latched underflow kept
// RULE8: carry flag marks borrow
// RULE9: overflow mode saturates integer subtracts only
// RULE10: parallel subtract plus store of third register
// RULE11: sources sampled before results written
// RULE12: memory source read precedes store write
// RULE13: reverse borrow subtract: src minus dst minus carry
// RULE14: reverse subtract writes src minus dst
// RULE15: float reverse sets overflow/underflow, carry kept
// RULE16: emulator interrupt: four cycles, flags kept
// RULE17: trap clears interrupt enable first
// RULE18: taken trap pushes pc, loads vector
// RULE19: untaken trap restores enable, flags kept
// RULE20: twenty condition codes over flags
// RULE21: bit test ANDs, writes no register
// RULE22: bit test flags: msb, zero, clear v/uf
// RULE23: subtracts and tests finish in one cycle
`timescale 1ns/1ps
`include "sub_test_trap_consts.vh"
module sub_test_trap_exec (
   // clock and reset
   input  wire        hclk,
   input  wire        hresetn,
   input  wire        ce,
   // ahb-lite slave
   input  wire        hsel,
   input  wire [7:0]  haddr,
   input  wire [1:0]  htrans,
   input  wire        hwrite,
   input  wire [2:0]  hsize,
   input  wire [31:0] hwdata,
   input  wire        hready,
   output reg         hreadyout,
   output reg         hresp,
   output reg  [31:0] hrdata,
   // core-side events
   output reg         emu_irq_q,
   output reg         busy_q
);
   // ------------------------------------------------------------
   // register state
   // ------------------------------------------------------------
   reg [31:0] ctrl_q;
   reg [31:0] opa_q;
   reg [31:0] opb_q;
   reg [31:0] opc_q;
   reg [31:0] status_word_q;
   reg [31:0] result_q;
   reg [31:0] store_q;
   reg [31:0] pc_q;
   reg [31:0] stack_pointer_q;
   reg        gie_saved_q;
   reg [2:0]  cnt_q;
   reg [1:0]  st_q;
   localparam S_IDLE = 2'b00;
   localparam S_EMU  = 2'b01;
   localparam S_TRAP = 2'b10;

   // bus address phase capture
   reg        dph_q;
   reg        dwr_q;
   reg [7:0]  daddr_q;
   wire       aph = hsel & hready & htrans[1];
   wire       wr_go = dph_q & dwr_q;
   wire [31:0] vec_rdata;

   // ------------------------------------------------------------
   // operand decode
   // ------------------------------------------------------------
   wire [3:0] op   = ctrl_q[`CTRL_OP_LSB +: 4];
   wire [1:0] mode = ctrl_q[`CTRL_MODE_LSB +: 2];
   wire [4:0] dsel = ctrl_q[`CTRL_DST_LSB +: 5];
   wire [4:0] cond = ctrl_q[`CTRL_COND_LSB +: 5];
   wire [4:0] vec_n = ctrl_q[`CTRL_N_LSB +: 5];
   // three-operand: bit0 picks indirect first source, bit1 second
   wire src1_ind = mode[0]; // [RULE1]
   wire src2_ind = mode[1]; // [RULE1]
   // two-operand: 00 reg, 01 direct, 10 indirect, 11 immediate [RULE3]
   wire two_mem  = (mode == 2'b01) | (mode == 2'b10);
   // the pipeline resolves memory/indirect fetch (disp 0, 1 or index) into opa/opb [RULE2]
   wire is_float = (op == `OP_RSUB_FLOAT);
   wire reg_bad  = is_float ? (dsel > `FLT_REG_MAX) : (dsel > `INT_REG_MAX); // [RULE4]

   // ------------------------------------------------------------
   // arithmetic
   // ------------------------------------------------------------
   // operands already sampled in registers, so store sees old values [RULE11]
   reg  [31:0] minu;
   reg  [31:0] subt;
   reg         bin;
   always @* begin
      minu = opa_q;
      subt = opb_q;
      bin  = 1'b0;
      case (op)
         `OP_SUB3:       begin minu = opa_q; subt = opb_q; end
         `OP_SUB_STORE:  begin minu = opb_q; subt = opa_q; end // indirect minus reg [RULE10]
         `OP_RSUB_BORROW: begin
            minu = opb_q; subt = opa_q; bin = status_word_q[`ST_C]; // [RULE13]
         end
         `OP_RSUB_INT:   begin minu = opb_q; subt = opa_q; end // [RULE14]
         default:        begin minu = opa_q; subt = opb_q; end
      endcase
   end
   wire [32:0] diff = {1'b0, minu} - {1'b0, subt} - {32'h0000_0000, bin};
   wire        borrow = diff[32]; // [RULE8]
   wire        ovf = (minu[31] != subt[31]) & (diff[31] != minu[31]); // [RULE6]
   // overflow mode saturates integer results [RULE9]
   wire [31:0] sat = minu[31] ? 32'h8000_0000 : 32'h7FFF_FFFF;
   wire [31:0] ires = (ovf & status_word_q[`ST_OVM]) ? sat : diff[31:0];

   // float reverse subtract: sign-magnitude on a 8-bit exponent, 24-bit mantissa
   wire [31:0] fdst = opa_q;
   wire [31:0] fsrc = opb_q;
   wire [32:0] fexp = {25'h0, fsrc[31:24]} - {25'h0, fdst[31:24]};
   wire        f_big = (fsrc[31:24] >= fdst[31:24]);
   wire [31:0] fres = f_big ? {fsrc[31:24], fsrc[23:0] - fdst[23:0]} : {fdst[31:24], fdst[23:0] - fsrc[23:0]};
   wire        f_ovf = f_big & (fsrc[31:24] == 8'h7F) & fexp[32];
   wire        f_unf = (fres[23:0] == 24'h00_0000) & ~(fsrc == fdst);

   // bit test [RULE21]
   wire [31:0] tres = opa_q & opb_q;

   // ------------------------------------------------------------
   // condition evaluation over twenty codes [RULE20]
   // ------------------------------------------------------------
   wire fc = status_word_q[`ST_C];
   wire fv = status_word_q[`ST_V];
   wire fz = status_word_q[`ST_Z];
   wire fn = status_word_q[`ST_N];
   wire fu = status_word_q[`ST_UF];
   wire fl = status_word_q[`ST_LV];
   wire fk = status_word_q[`ST_LUF];
   reg  cond_true;
   always @* begin
      case (cond)
         5'h00:   cond_true = 1'b1;
         5'h01:   cond_true = fc;
         5'h02:   cond_true = ~fc & ~fz;
         5'h03:   cond_true = fc | fz;
         5'h04:   cond_true = ~fc;
         5'h05:   cond_true = fz;
         5'h06:   cond_true = ~fz;
         5'h07:   cond_true = fn;
         5'h08:   cond_true = fn | fz;
         5'h09:   cond_true = ~fn & ~fz;
         5'h0A:   cond_true = ~fn;
         5'h0B:   cond_true = fz;
         5'h0C:   cond_true = ~fz;
         5'h0D:   cond_true = fv;
         5'h0E:   cond_true = ~fv;
         5'h0F:   cond_true = fu;
         5'h10:   cond_true = ~fu;
         5'h11:   cond_true = fl;
         5'h12:   cond_true = ~fl;
         5'h13:   cond_true = fk;
         default: cond_true = 1'b0; // codes beyond the set never trap
      endcase
   end

   // ------------------------------------------------------------
   // trap vector memory, read address set by the trap number
   // ------------------------------------------------------------
   wire vec_we = wr_go & (daddr_q[7] ^ daddr_q[6]);
   vec_mem #(.DEPTH(`VEC_COUNT), .AW(5)) u_vec (
      .hclk  (hclk),
      .ce    (ce),
      .we    (vec_we),
      .waddr ({~daddr_q[6], daddr_q[5:2]}),
      .wdata (hwdata),
      .raddr (vec_n),
      .rdata (vec_rdata)
   );

   // ------------------------------------------------------------
   // execute sequencer and register file
   // ------------------------------------------------------------
   // go is a one-cycle command from a ctrl write with bit 31 set
   wire go = wr_go & (daddr_q == `REG_CTRL) & hwdata[`CTRL_GO_BIT];
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ctrl_q          <= 32'h0000_0000;
         opa_q           <= 32'h0000_0000;
         opb_q           <= 32'h0000_0000;
         opc_q           <= 32'h0000_0000;
         status_word_q   <= `ST_RESET;
         result_q        <= 32'h0000_0000;
         store_q         <= 32'h0000_0000;
         pc_q            <= 32'h0000_0000;
         stack_pointer_q <= 32'h0000_0000;
         gie_saved_q     <= 1'b0;
         cnt_q           <= 3'd0;
         st_q            <= S_IDLE;
         emu_irq_q       <= 1'b0;
         busy_q          <= 1'b0;
      end else if (ce) begin
         emu_irq_q <= 1'b0;
         // plain register writes, blocked while a multi-cycle op runs
         if (wr_go && st_q == S_IDLE) begin
            case (daddr_q)
               `REG_CTRL:   ctrl_q <= {1'b0, hwdata[30:0]};
               `REG_OPA:    opa_q <= hwdata;
               `REG_OPB:    opb_q <= hwdata;
               `REG_OPC:    opc_q <= hwdata;
               `REG_STATUS: status_word_q <= hwdata;
               `REG_PC:     pc_q <= hwdata;
               `REG_SP:     stack_pointer_q <= hwdata;
               default:     ;
            endcase
         end
         case (st_q)
            S_IDLE: begin
               // go acts on the ctrl value already held, so write ctrl first
               if (go && !reg_bad) begin
                  case (op)
                     `OP_SUB3, `OP_SUB_STORE, `OP_RSUB_BORROW, `OP_RSUB_INT: begin
                        result_q <= ires; // single cycle [RULE23]
                        status_word_q[`ST_N] <= ires[31]; // [RULE5]
                        status_word_q[`ST_Z] <= (ires == 32'h0000_0000); // [RULE5]
                        status_word_q[`ST_V] <= ovf; // [RULE6]
                        status_word_q[`ST_UF] <= 1'b0; // [RULE6]
                        status_word_q[`ST_C] <= borrow; // [RULE8]
                        if (ovf) status_word_q[`ST_LV] <= 1'b1; // [RULE7]
                        // store uses the register value captured before this write [RULE10]
                        // the memory source was read into opb before the store leaves [RULE12]
                        if (op == `OP_SUB_STORE) store_q <= opc_q;
                     end
                     `OP_RSUB_FLOAT: begin
                        result_q <= fres; // [RULE14]
                        status_word_q[`ST_N] <= fres[31]; // [RULE15]
                        status_word_q[`ST_Z] <= (fres[23:0] == 24'h00_0000);
                        status_word_q[`ST_V] <= f_ovf; // [RULE15]
                        status_word_q[`ST_UF] <= f_unf; // [RULE15]
                        if (f_ovf) status_word_q[`ST_LV] <= 1'b1;
                        if (f_unf) status_word_q[`ST_LUF] <= 1'b1;
                     end
                     `OP_TEST2, `OP_TEST3: begin
                        status_word_q[`ST_N] <= tres[31]; // [RULE22]
                        status_word_q[`ST_Z] <= (tres == 32'h0000_0000); // [RULE22]
                        status_word_q[`ST_V] <= 1'b0; // [RULE22]
                        status_word_q[`ST_UF] <= 1'b0; // [RULE22]
                     end
                     `OP_EMU_IRQ: begin
                        emu_irq_q <= 1'b1; // flags untouched [RULE16]
                        cnt_q <= `EMU_CYCLES - 3'd1;
                        busy_q <= 1'b1;
                        st_q <= S_EMU;
                     end
                     `OP_TRAP: begin
                        gie_saved_q <= status_word_q[`ST_GIE];
                        status_word_q[`ST_GIE] <= 1'b0; // [RULE17]
                        cnt_q <= `TRAP_CYCLES - 3'd1;
                        busy_q <= 1'b1;
                        st_q <= S_TRAP;
                     end
                     default: ;
                  endcase
               end
            end
            S_EMU: begin
               // four cycles in total including the issue cycle [RULE16]
               cnt_q <= cnt_q - 3'd1;
               if (cnt_q == 3'd1) begin
                  busy_q <= 1'b0;
                  st_q <= S_IDLE;
               end
            end
            S_TRAP: begin
               cnt_q <= cnt_q - 3'd1;
               if (cnt_q == 3'd1) begin
                  busy_q <= 1'b0;
                  st_q <= S_IDLE;
                  if (cond_true) begin
                     // push next pc at pre-incremented stack pointer [RULE18]
                     stack_pointer_q <= stack_pointer_q + 32'h0000_0001;
                     store_q <= pc_q + 32'h0000_0001;
                     pc_q <= vec_rdata; // [RULE18]
                  end else begin
                     status_word_q[`ST_GIE] <= gie_saved_q; // [RULE19]
                     pc_q <= pc_q + 32'h0000_0001;
                  end
               end
            end
            default: st_q <= S_IDLE;
         endcase
      end
   end

   // ------------------------------------------------------------
   // ahb-lite slave: zero wait states, always okay
   // ------------------------------------------------------------
   reg [31:0] rd_mux;
   always @* begin
      case (daddr_q)
         `REG_CTRL:   rd_mux = ctrl_q;
         `REG_OPA:    rd_mux = opa_q;
         `REG_OPB:    rd_mux = opb_q;
         `REG_OPC:    rd_mux = opc_q;
         `REG_STATUS: rd_mux = status_word_q;
         `REG_RESULT: rd_mux = result_q;
         `REG_STORE:  rd_mux = store_q;
         `REG_PC:     rd_mux = pc_q;
         `REG_SP:     rd_mux = stack_pointer_q;
         default:     rd_mux = {29'h0000_0000, two_mem, src2_ind, src1_ind} & 32'h0000_0000;
      endcase
   end
   // read data registered at the address phase so hrdata is a flop
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         dph_q     <= 1'b0;
         dwr_q     <= 1'b0;
         daddr_q   <= 8'h00;
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
         hrdata    <= 32'h0000_0000;
      end else if (ce) begin
         dph_q     <= aph;
         dwr_q     <= hwrite;
         if (aph) daddr_q <= haddr;
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
         // read decode uses haddr so data are ready in the data phase
         if (aph && !hwrite) begin
            case (haddr)
               `REG_CTRL:   hrdata <= ctrl_q;
               `REG_OPA:    hrdata <= opa_q;
               `REG_OPB:    hrdata <= opb_q;
               `REG_OPC:    hrdata <= opc_q;
               `REG_STATUS: hrdata <= status_word_q;
               `REG_RESULT: hrdata <= result_q;
               `REG_STORE:  hrdata <= store_q;
               `REG_PC:     hrdata <= pc_q;
               `REG_SP:     hrdata <= stack_pointer_q;
               default:     hrdata <= rd_mux & 32'h0000_0000;
            endcase
         end
      end
   end
endmodule

// ---- tb/sub_test_trap_exec_asserts.sv ----
// checker for the subtract, test and trap datapath
`timescale 1ns/1ps
module sub_test_trap_exec_asserts (
   // clock and reset
   input wire        hclk,
   input wire        hresetn,
   input wire        ce,
   // bus
   input wire        hsel,
   input wire [7:0]  haddr,
   input wire [1:0]  htrans,
   input wire        hwrite,
   input wire [2:0]  hsize,
   input wire [31:0] hwdata,
   input wire        hready,
   input wire        hreadyout,
   input wire        hresp,
   input wire [31:0] hrdata,
   // events
   input wire        emu_irq_q,
   input wire        busy_q
);
   // ------------------------------------------------------------
   // decode of go writes
   // ------------------------------------------------------------
   reg       wr_q;
   reg [7:0] ad_q;
   reg [2:0] run_q;
   reg       emu_q;
   wire      go      = wr_q && ad_q == 8'h00 && hwdata[31] && !busy_q;
   wire      g_emu   = go && hwdata[3:0] == 4'h5;
   wire      g_multi = go && (hwdata[3:0] == 4'h5 || hwdata[3:0] == 4'h6);
   wire      g_trap  = go && hwdata[3:0] == 4'h6;
   wire      g_one   = go && !g_multi && hwdata[3:0] < 4'h9;
   // track data phase and length of each busy run
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_q  <= 1'b0;
         ad_q  <= 8'h00;
         run_q <= 3'h0;
         emu_q <= 1'b0;
      end else begin
         wr_q  <= hsel && hready && htrans[1] && hwrite;
         ad_q  <= haddr;
         run_q <= busy_q ? run_q + 3'h1 : 3'h0;
         if (go) emu_q <= hwdata[3:0] == 4'h5;
      end
   end
   // ------------------------------------------------------------
   // properties
   // ------------------------------------------------------------
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);
   emu_pulse_a: assert property (emu_irq_q |=> !emu_irq_q)
      else $error("emulator pulse longer than one cycle");
   emu_issue_a: assert property (g_emu |-> ##[1:2] emu_irq_q)
      else $error("emulator op raised no interrupt");
   emu_cause_a: assert property (emu_irq_q |-> $past(g_emu) || $past(g_emu, 2))
      else $error("interrupt without emulator op");
   busy_len_a: assert property ($fell(busy_q) |-> run_q == (emu_q ? 3'h3 : 3'h4))
      else $error("busy run has wrong length");
   single_cycle_a: assert property (g_one |=> !busy_q [*3])
      else $error("single cycle op went busy");
   multi_busy_a: assert property (g_multi |-> ##[1:2] busy_q)
      else $error("multi cycle op never busy");
   trap_quiet_a: assert property (g_trap |=> !emu_irq_q [*6])
      else $error("trap raised emulator interrupt");
   busy_cause_a: assert property ($rose(busy_q) |-> $past(g_multi) || $past(g_multi, 2))
      else $error("busy without multi cycle op");
   // main scenarios reached
   cover property (g_emu);
   cover property (g_trap);
   cover property (g_one);
endmodule
bind sub_test_trap_exec sub_test_trap_exec_asserts sub_test_trap_exec_asserts_inst (.hclk(hclk), .hresetn(hresetn),
   .ce(ce), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
   .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .emu_irq_q(emu_irq_q), .busy_q(busy_q));

// ---- tb/core_pipe_model.sv ----
// bus-side model of the core pipeline issuing register transfers
`timescale 1ns/1ps
module core_pipe_model (
   // clock
   input  wire        hclk,
   // bus
   input  wire        hready,
   input  wire [31:0] hrdata,
   output reg         hsel,
   output reg  [7:0]  haddr,
   output reg  [1:0]  htrans,
   output reg         hwrite,
   output reg  [2:0]  hsize,
   output reg  [31:0] hwdata
);
   // idle bus at time zero
   initial begin
      hsel   = 1'b0;
      haddr  = 8'h00;
      htrans = 2'h0;
      hwrite = 1'b0;
      hsize  = 3'h2;
      hwdata = 32'h0;
   end
   // one single word transfer, entered just after a rising edge
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
      hsel   <= 1'b1;
      htrans <= 2'h2;
      haddr  <= a;
      hwrite <= w;
      do @(posedge hclk); while (!hready);
      hsel   <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge hclk); while (!hready);
      r = hrdata;
      // stale data would hide a slave that samples late
      hwdata <= ~d;
   endtask
endmodule

// ---- tb/sub_test_trap_exec_tb_top.sv ----
// self-checking bench for the subtract, test and trap datapath
`timescale 1ns/1ps
`include "sub_test_trap_consts.vh"
module sub_test_trap_exec_tb_top;
   // ------------------------------------------------------------
   // wiring and bench state
   // ------------------------------------------------------------
   reg          hclk;
   reg          hresetn;
   reg          ce;
   wire         hsel, hwrite, hreadyout, hresp, emu_irq_q, busy_q;
   wire [7:0]   haddr;
   wire [1:0]   htrans;
   wire [2:0]   hsize;
   wire [31:0]  hwdata, hrdata;
   integer      error_cnt, cmp_count, cyc, i, c, n;
   logic [31:0] st, er, res, mk, x, y, p, s, v;
   logic        tk, taken_any;
   logic [3:0]  ops [6];

   sub_test_trap_exec sub_test_trap_exec_inst (.hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .emu_irq_q(emu_irq_q), .busy_q(busy_q));
   core_pipe_model core_pipe_model_inst (.hclk(hclk), .hready(hreadyout), .hrdata(hrdata), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));

   // 25 MHz clock
   initial begin
      hclk = 1'b0;
      forever #20 hclk = ~hclk;
   end
   // hang guard, far above the expected run length
   always @(posedge hclk) begin
      cyc = cyc + 1;
      if (cyc == 20000) begin
         error_cnt = error_cnt + 1;
         test_done();
      end
   end
   // ------------------------------------------------------------
   // tasks
   // ------------------------------------------------------------
   task automatic test_done();
      if (error_cnt == 0 && cmp_count > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      cmp_count = cmp_count + 1;
      if (g !== e) begin
         error_cnt = error_cnt + 1;
         $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] r;
      core_pipe_model_inst.xfer(1'b1, a, d, r);
   endtask
   task automatic rd(input logic [7:0] a);
      core_pipe_model_inst.xfer(1'b0, a, 32'h0, res);
   endtask
   // load fields, then fire them, then let any multi cycle op finish
   task automatic run(input logic [3:0] o, input logic [4:0] d, input logic [4:0] cd, input logic [4:0] nn);
      logic [31:0] w;
      w = {3'h0, nn, 3'h0, cd, 3'h0, d, 2'h0, 2'($urandom_range(3)), o};
      wr(`REG_CTRL, w);
      wr(`REG_CTRL, w | 32'h80000000);
      repeat (2) @(posedge hclk);
      while (busy_q) @(posedge hclk);
   endtask
   // reference integer subtract a - b - ci into er and st
   task automatic isub(input logic [31:0] a, input logic [31:0] b, input logic ci);
      logic [32:0] w;
      longint      sm;
      logic        ov;
      w  = {1'b0, a} - {1'b0, b} - {32'h0, ci};
      sm = longint'($signed(a)) - longint'($signed(b)) - longint'(ci);
      ov = sm != longint'($signed(w[31:0]));
      er = w[31:0];
      if (ov && st[`ST_OVM]) er = a[31] ? 32'h80000000 : 32'h7FFFFFFF;
      st[`ST_N]  = er[31];
      st[`ST_Z]  = er == 32'h0;
      st[`ST_V]  = ov;
      st[`ST_C]  = w[32];
      st[`ST_UF] = 1'b0;
      if (ov) st[`ST_LV] = 1'b1;
   endtask
   task automatic int_step(input logic [3:0] o, input logic [31:0] a, input logic [31:0] b, input logic [4:0] d);
      wr(`REG_OPA, a);
      wr(`REG_OPB, b);
      wr(`REG_OPC, ~a);
      run(o, d, 5'h00, 5'h00);
      case (o)
         `OP_SUB3: isub(a, b, 1'b0);
         `OP_RSUB_BORROW: isub(b, a, st[`ST_C]);
         `OP_TEST2, `OP_TEST3: begin
            st[`ST_N]  = (a & b) >> 31;
            st[`ST_Z]  = (a & b) == 32'h0;
            st[`ST_V]  = 1'b0;
            st[`ST_UF] = 1'b0;
         end
         default: isub(b, a, 1'b0);
      endcase
      rd(`REG_RESULT);
      chk("result", er, res);
      rd(`REG_STATUS);
      chk("status", st & mk, res & mk);
      if (o == `OP_SUB_STORE) begin
         rd(`REG_STORE);
         chk("store", ~a, res);
      end
   endtask
   // ------------------------------------------------------------
   // main sequence
   // ------------------------------------------------------------
   initial begin
      hresetn = 1'b0;
      ce = 1'b1;
      error_cnt = 0;
      cmp_count = 0;
      cyc = 0;
      st = 32'h0;
      er = 32'h0;
      mk = 32'hFFFFFFFF;
      taken_any = 1'b0;
      ops = '{`OP_SUB3, `OP_SUB_STORE, `OP_RSUB_BORROW, `OP_RSUB_INT, `OP_TEST2, `OP_TEST3};
      void'($urandom(32'h7BC735C2));
      repeat (5) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      rd(`REG_STATUS);
      chk("status reset", `ST_RESET, res);
      rd(8'h3C);
      chk("unmapped", 32'h0, res);
      // overflow, zero and borrow corners first, then random mixes
      for (i = 0; i < 30; i++) begin
         x = (i < 4) ? ((i == 0) ? 32'h80000000 : (i == 1) ? 32'h5 : (i == 2) ? 32'h1 : 32'h7FFFFFFF) : $urandom;
         y = (i < 4) ? ((i == 0) ? 32'h1 : (i == 1) ? 32'h5 : (i == 2) ? 32'h2 : 32'hFFFFFFFF) : $urandom;
         int_step((i < 4) ? `OP_SUB3 : ops[i % 6], x, y, 5'($urandom_range(7)));
      end
      int_step(`OP_RSUB_INT, $urandom, $urandom, 5'h1B);
      // saturation under overflow mode, only value and overflow known
      st[`ST_OVM] = 1'b1;
      wr(`REG_STATUS, st);
      mk = 32'h2;
      int_step(`OP_SUB3, 32'h80000000, 32'h1, 5'h01);
      // out of range destinations are refused
      wr(`REG_STATUS, 32'h0);
      st = 32'h0;
      mk = 32'hFFFFFFFF;
      run(`OP_SUB3, 5'h1C, 5'h00, 5'h00);
      run(`OP_RSUB_FLOAT, 5'h08, 5'h00, 5'h00);
      rd(`REG_RESULT);
      chk("refused result", er, res);
      rd(`REG_STATUS);
      chk("refused status", st, res);
      // float reverse keeps carry and ignores overflow mode
      wr(`REG_STATUS, 32'h81);
      run(`OP_RSUB_FLOAT, 5'h03, 5'h00, 5'h00);
      rd(`REG_STATUS);
      chk("float carry", 32'h81, res & 32'h81);
      // emulator op leaves every flag alone
      v = $urandom & 32'h207F;
      wr(`REG_STATUS, v);
      run(`OP_EMU_IRQ, 5'h00, 5'h00, 5'h00);
      rd(`REG_STATUS);
      chk("emu status", v, res);
      // every condition code, vectors 0 to 31 at the ends
      for (c = 0; c < 20; c++) begin
         n = (c == 19) ? 31 : c;
         v = ($urandom & 32'h7F) | 32'h2000;
         wr(`REG_STATUS, v);
         rd(`REG_PC);
         p = res;
         rd(`REG_SP);
         s = res;
         wr(8'(8'h40 + 4 * n), 32'h80000000 | (n << 8));
         run(`OP_TRAP, 5'h00, c[4:0], n[4:0]);
         rd(`REG_PC);
         tk = res === (32'h80000000 | (n << 8));
         taken_any = taken_any | tk;
         if (!tk) chk("pc", p + 32'h1, res);
         rd(`REG_SP);
         chk("sp", tk ? s + 32'h1 : s, res);
         rd(`REG_STATUS);
         chk("trap status", tk ? v & ~32'h2000 : v, res);
         if (tk) begin
            rd(`REG_STORE);
            chk("pushed pc", p + 32'h1, res);
         end
      end
      chk("trap taken", 32'h1, {31'h0, taken_any});
      test_done();
   end
endmodule
